/* hdl/ipc_irq_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_irq_arbiter #(
	parameter logic [15:0] BASE_ADDR = 16'hf0e0
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic busSel,
	input wire logic busWr,
	input wire logic [15:0] busAddr,
	input wire logic [15:0] busWdata,
	output logic [15:0] busRdata,
	output logic busRdValid,
	input wire logic [ipc_pkg::NUM_SRC-1:0] irqReq,
	input wire logic [1:0] coreMask,
	input wire logic lowPowerMode,
	output logic irqAsserted,
	output logic [1:0] irqLevel,
	output logic [ipc_pkg::VEC_W-1:0] vecNum,
	output logic [ipc_pkg::ADDR_W-1:0] vecAddr,
	output logic fastHit,
	output logic wakeReq
);
	import ipc_pkg::*;

	// ----------------------------------------------------------------
	// Writable masks of the priority registers
	// ----------------------------------------------------------------
	localparam logic [15:0] PRIO0_WMASK =
		(16'h3 << CLOCK_LOCK_LSB) |
		(16'h3 << LOW_VOLTAGE_LSB) |
		(16'h3 << DEBUG_RX_FULL_LSB) |
		(16'h3 << DEBUG_TX_EMPTY_LSB) |
		(16'h3 << DEBUG_TRACE_LSB) |
		(16'h3 << DEBUG_BREAKPOINT_LSB) |
		(16'h3 << DEBUG_STEP_LSB);
	localparam logic [15:0] PRIO1_WMASK =
		(16'h3 << PORT_D_LSB) |
		(16'h3 << FLASH_BUFFERS_EMPTY_LSB) |
		(16'h3 << FLASH_DONE_LSB) |
		(16'h3 << FLASH_FAULT_LSB);
	localparam logic [15:0] PRIO_OTHER_WMASK = 16'hffff;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic [15:0] offsFull;
	logic inRange;
	logic [4:0] offs;
	logic wrHit;
	logic rdHit;

	assign offsFull = busAddr - BASE_ADDR;
	assign inRange = (offsFull[15:5] == 11'h000);
	assign offs = offsFull[4:0];
	assign wrHit = busSel && busWr && inRange;
	assign rdHit = busSel && !busWr;

	// ----------------------------------------------------------------
	// Priority registers
	// ----------------------------------------------------------------
	logic [15:0] prio [NUM_PRIO];

	genvar r;
	generate
		for (r = 0; r < NUM_PRIO; r++)
		begin : g_prio
			localparam logic [15:0] WM = (r == 0) ? PRIO0_WMASK :
				(r == 1) ? PRIO1_WMASK : PRIO_OTHER_WMASK;
			ipc_field_reg #(
				.WMASK(WM),
				.RST(PRIO_RST)
			) u_prio (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.wrEn(wrHit && (offs == 5'(r))),
				.wdata(busWdata),
				.q(prio[r])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Vector base, fast interrupt and control registers
	// ----------------------------------------------------------------
	logic [15:0] vba_r;
	logic [15:0] fastMatch_r [2];
	logic [15:0] fastLow_r [2];
	logic [15:0] fastHigh_r [2];
	logic globalOff_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vba_r <= CFG_RST;
			fastMatch_r[0] <= CFG_RST;
			fastMatch_r[1] <= CFG_RST;
			fastLow_r[0] <= CFG_RST;
			fastLow_r[1] <= CFG_RST;
			fastHigh_r[0] <= CFG_RST;
			fastHigh_r[1] <= CFG_RST;
			globalOff_r <= 1'b0;
		end
		else if (wrHit)
		begin
			case (offs)
				OFF_VBA: vba_r <= busWdata;
				OFF_FAST_MATCH_0: fastMatch_r[0] <= busWdata;
				OFF_FAST_LOW_0: fastLow_r[0] <= busWdata;
				OFF_FAST_HIGH_0: fastHigh_r[0] <= busWdata;
				OFF_FAST_MATCH_1: fastMatch_r[1] <= busWdata;
				OFF_FAST_LOW_1: fastLow_r[1] <= busWdata;
				OFF_FAST_HIGH_1: fastHigh_r[1] <= busWdata;
				OFF_CTRL: globalOff_r <= busWdata[CTRL_GLOBAL_OFF_BIT];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Per-source level decode
	// ----------------------------------------------------------------
	logic [1:0] code [NUM_SRC];
	logic [1:0] srcLevel [NUM_SRC];
	logic [NUM_SRC-1:0] enabled;
	logic [NUM_SRC-1:0] active;

	genvar s;
	generate
		for (s = 0; s < NUM_SRC; s++)
		begin : g_src
			if (s < NUM_FIELD_SRC)
			begin : g_field
				// Lowest source of a register sits in its top field
				assign code[s] = prio[s / FIELDS_PER_REG][2 * (7 - (s % FIELDS_PER_REG)) +: 2];
			end
			else
			begin : g_fixed
				assign code[s] = LEVEL_OFF;
			end
			// First register codes levels 1..3, the rest levels 0..2
			if (s < FIELDS_PER_REG)
			begin : g_hi
				assign srcLevel[s] = code[s];
			end
			else
			begin : g_lo
				assign srcLevel[s] = code[s] - 2'h1;
			end
			assign enabled[s] = (code[s] != LEVEL_OFF) && !globalOff_r;
			assign active[s] = irqReq[s] && enabled[s];
		end
	endgenerate

	// ----------------------------------------------------------------
	// One encoder per priority level
	// ----------------------------------------------------------------
	logic [NUM_LEVELS-1:0] lvlFound;
	logic [VEC_W-1:0] lvlIdx [NUM_LEVELS];

	genvar l;
	generate
		for (l = 0; l < NUM_LEVELS; l++)
		begin : g_lvl
			ipc_find_if #(.N(NUM_SRC)) fi ();
			always_comb
			begin
				for (int k = 0; k < NUM_SRC; k++)
				begin
					fi.req[k] = active[k] && (srcLevel[k] == 2'(l));
				end
			end
			ipc_first_set #(.N(NUM_SRC)) u_enc (
				.f(fi.enc)
			);
			assign lvlFound[l] = fi.found;
			assign lvlIdx[l] = fi.idx;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Winner and vector address
	// ----------------------------------------------------------------
	logic winFound;
	logic [1:0] winLvl;
	logic [VEC_W-1:0] winIdx;
	logic winPresent;
	logic [1:0] fastSel;
	logic [ADDR_W-1:0] winAddr;

	always_comb
	begin
		winFound = 1'b0;
		winLvl = 2'h0;
		winIdx = '0;
		for (int k = 0; k < NUM_LEVELS; k++)
		begin
			if (lvlFound[k])
			begin
				winFound = 1'b1;
				winLvl = 2'(k);
				winIdx = lvlIdx[k];
			end
		end
	end

	// Core mask permits levels at or above its value
	assign winPresent = winFound && (winLvl >= coreMask);

	always_comb
	begin
		for (int k = 0; k < 2; k++)
		begin
			fastSel[k] = (winLvl == FAST_LEVEL) && (fastMatch_r[k][VEC_W-1:0] == winIdx);
		end
		if (fastSel[0])
			winAddr = {fastHigh_r[0][FAST_HIGH_W-1:0], fastLow_r[0]};
		else if (fastSel[1])
			winAddr = {fastHigh_r[1][FAST_HIGH_W-1:0], fastLow_r[1]};
		else
			winAddr = {vba_r, winIdx};
	end

	// ----------------------------------------------------------------
	// Core-facing outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqAsserted <= 1'b0;
			irqLevel <= 2'h0;
			vecNum <= '0;
			vecAddr <= '0;
			fastHit <= 1'b0;
		end
		else
		begin
			irqAsserted <= winPresent;
			irqLevel <= winPresent ? winLvl : 2'h0;
			vecNum <= winPresent ? winIdx : '0;
			vecAddr <= winPresent ? winAddr : '0;
			fastHit <= winPresent && (fastSel != 2'b00);
		end
	end

	// ----------------------------------------------------------------
	// Wake request in wait and stop
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] entrySnap_r;

	// Enables are frozen at entry; later enables cannot wake
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			entrySnap_r <= '0;
		else if (!lowPowerMode)
			entrySnap_r <= enabled;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wakeReq <= 1'b0;
		else
			wakeReq <= lowPowerMode && ((active & entrySnap_r) != '0);
	end

	// ----------------------------------------------------------------
	// Status views
	// ----------------------------------------------------------------
	logic [NUM_SRC-1:0] pend_r;
	logic [1:0] ipic;
	logic [15:0] ctrlView;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pend_r <= '0;
		else
			pend_r <= active;
	end

	always_comb
	begin
		case (irqLevel)
			2'h0: ipic = 2'h1;
			2'h1: ipic = 2'h2;
			default: ipic = 2'h3;
		endcase
		if (!irqAsserted)
			ipic = 2'h0;
		ctrlView = 16'h0000;
		ctrlView[CTRL_IPIC_LSB +: 2] = ipic;
		ctrlView[CTRL_LOWPOWER_BIT] = lowPowerMode;
		ctrlView[CTRL_PRESENT_BIT] = irqAsserted;
		ctrlView[CTRL_GLOBAL_OFF_BIT] = globalOff_r;
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [15:0] rdMux;
	logic [4:0] pendSel;

	assign pendSel = offs - OFF_PEND_FIRST;

	always_comb
	begin
		rdMux = 16'h0000;
		if (inRange)
		begin
			if (offs <= OFF_PRIO_LAST)
				rdMux = prio[offs[2:0]];
			else if (offs == OFF_VBA)
				rdMux = vba_r;
			else if (offs == OFF_FAST_MATCH_0)
				rdMux = fastMatch_r[0];
			else if (offs == OFF_FAST_LOW_0)
				rdMux = fastLow_r[0];
			else if (offs == OFF_FAST_HIGH_0)
				rdMux = fastHigh_r[0];
			else if (offs == OFF_FAST_MATCH_1)
				rdMux = fastMatch_r[1];
			else if (offs == OFF_FAST_LOW_1)
				rdMux = fastLow_r[1];
			else if (offs == OFF_FAST_HIGH_1)
				rdMux = fastHigh_r[1];
			else if (offs >= OFF_PEND_FIRST && offs <= OFF_PEND_LAST)
				rdMux = pend_r[16 * pendSel[1:0] +: 16];
			else if (offs == OFF_CTRL)
				rdMux = ctrlView;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busRdata <= 16'h0000;
			busRdValid <= 1'b0;
		end
		else
		begin
			busRdValid <= rdHit;
			busRdata <= rdHit ? rdMux : 16'h0000;
		end
	end
endmodule
`default_nettype wire

/* include/ipc_pkg.sv */
`default_nettype none
package ipc_pkg;
	// ----------------------------------------------------------------
	// Register offsets, in words above the module base
	// ----------------------------------------------------------------
	localparam logic [4:0] OFF_PRIO_FIRST = 5'h00;
	localparam logic [4:0] OFF_PRIO_LAST = 5'h06;
	localparam logic [4:0] OFF_VBA = 5'h07;
	localparam logic [4:0] OFF_FAST_MATCH_0 = 5'h08;
	localparam logic [4:0] OFF_FAST_LOW_0 = 5'h09;
	localparam logic [4:0] OFF_FAST_HIGH_0 = 5'h0a;
	localparam logic [4:0] OFF_FAST_MATCH_1 = 5'h0b;
	localparam logic [4:0] OFF_FAST_LOW_1 = 5'h0c;
	localparam logic [4:0] OFF_FAST_HIGH_1 = 5'h0d;
	localparam logic [4:0] OFF_PEND_FIRST = 5'h0e;
	localparam logic [4:0] OFF_PEND_LAST = 5'h11;
	localparam logic [4:0] OFF_CTRL = 5'h16;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_PRIO = 7;
	localparam int FIELDS_PER_REG = 8;
	localparam int NUM_SRC = 64;
	localparam int NUM_FIELD_SRC = NUM_PRIO * FIELDS_PER_REG;
	localparam int NUM_LEVELS = 4;
	localparam int VEC_W = 6;
	localparam int ADDR_W = 22;
	localparam int FAST_HIGH_W = ADDR_W - 16;
	// ----------------------------------------------------------------
	// Priority field positions
	// ----------------------------------------------------------------
	localparam int CLOCK_LOCK_LSB = 14;
	localparam int LOW_VOLTAGE_LSB = 12;
	localparam int DEBUG_RX_FULL_LSB = 8;
	localparam int DEBUG_TX_EMPTY_LSB = 6;
	localparam int DEBUG_TRACE_LSB = 4;
	localparam int DEBUG_BREAKPOINT_LSB = 2;
	localparam int DEBUG_STEP_LSB = 0;
	localparam int PORT_D_LSB = 14;
	localparam int FLASH_BUFFERS_EMPTY_LSB = 4;
	localparam int FLASH_DONE_LSB = 2;
	localparam int FLASH_FAULT_LSB = 0;
	localparam logic [1:0] LEVEL_OFF = 2'h0;
	localparam logic [1:0] FAST_LEVEL = 2'h2;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_IPIC_LSB = 14;
	localparam int CTRL_LOWPOWER_BIT = 13;
	localparam int CTRL_PRESENT_BIT = 12;
	localparam int CTRL_GLOBAL_OFF_BIT = 5;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] PRIO_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;
endpackage
`default_nettype wire

/* include/ipc_find_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ipc_find_if #(parameter int N = 64);
	logic [N-1:0] req;
	logic found;
	logic [$clog2(N)-1:0] idx;
	modport enc (input req, output found, output idx);
	modport user (output req, input found, input idx);
endinterface
`default_nettype wire

/* hdl/ipc_first_set.sv */
`timescale 1ns/1ps
`default_nettype none
// Finds the lowest numbered active request
module ipc_first_set #(
	parameter int N = 64
)(
	ipc_find_if.enc f
);
	localparam int IW = $clog2(N);

	always_comb
	begin
		f.found = 1'b0;
		f.idx = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (f.req[i])
			begin
				f.found = 1'b1;
				f.idx = IW'(i);
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/ipc_field_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// Software register whose unwritable bits always read as zero
module ipc_field_reg #(
	parameter logic [15:0] WMASK = 16'hffff,
	parameter logic [15:0] RST = 16'h0000
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [15:0] wdata,
	output logic [15:0] q
);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= RST & WMASK;
		else if (wrEn)
			q <= wdata & WMASK;
	end
endmodule
`default_nettype wire

/* bench/ipc_arbiter_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_arbiter_checker #(
	parameter logic [15:0] BASE_ADDR = 16'hf0e0
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic busSel,
	input wire logic busWr,
	input wire logic [15:0] busAddr,
	input wire logic [15:0] busRdata,
	input wire logic busRdValid,
	input wire logic [ipc_pkg::NUM_SRC-1:0] irqReq,
	input wire logic lowPowerMode,
	input wire logic irqAsserted,
	input wire logic [1:0] irqLevel,
	input wire logic [ipc_pkg::VEC_W-1:0] vecNum,
	input wire logic [ipc_pkg::ADDR_W-1:0] vecAddr,
	input wire logic fastHit,
	input wire logic wakeReq
);
	import ipc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_READ_ANSWER: assert property (busSel && !busWr |=> busRdValid)
		else $error("read not answered");
	AST_NO_SPURIOUS: assert property (!(busSel && !busWr) |=> !busRdValid && busRdata == 16'h0000)
		else $error("read data without request");
	AST_PRIO0_RESERVED: assert property (busSel && !busWr && busAddr == BASE_ADDR |=> busRdata[11:10] == 2'h0)
		else $error("reserved bits of level register 0 set");
	AST_PRIO1_RESERVED: assert property (busSel && !busWr && busAddr == BASE_ADDR + 16'h0001 |=> busRdata[13:6] == 8'h00)
		else $error("reserved bits of level register 1 set");
	AST_WAKE_AWAKE: assert property (!lowPowerMode |=> !wakeReq)
		else $error("wake while running");
	AST_IDLE_QUIET: assert property (irqReq == '0 |=> !irqAsserted && !wakeReq && !fastHit)
		else $error("request presented with no line active");
	AST_RESET_CLEAR: assert property ($rose(rst_n) |-> !irqAsserted && !busRdValid && !wakeReq && irqLevel == 2'h0)
		else $error("outputs not clear after reset");
	AST_FAST_LEVEL: assert property (fastHit |-> irqAsserted && irqLevel == FAST_LEVEL)
		else $error("fast handling off level 2");
	AST_BASE_VECTOR: assert property (irqAsserted && !fastHit |-> vecAddr[5:0] == vecNum)
		else $error("vector address does not end in vector number");
endmodule
bind ipc_irq_arbiter ipc_arbiter_checker #(.BASE_ADDR(BASE_ADDR)) chk (.sys_clk, .rst_n, .busSel, .busWr,
	.busAddr, .busRdata, .busRdValid, .irqReq, .lowPowerMode, .irqAsserted, .irqLevel, .vecNum,
	.vecAddr, .fastHit, .wakeReq);
`default_nettype wire

/* bench/ipc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_core_model (
	input wire logic sysClk,
	input wire logic rstN,
	input wire logic [1:0] maskIn,
	input wire logic sleepIn,
	input wire logic wakeReq,
	output logic [1:0] coreMask,
	output logic lowPowerMode
);
	assign coreMask = maskIn;
	// Clocks stop on request and restart once the controller asks
	always_ff @(posedge sysClk or negedge rstN)
	begin
		if (!rstN)
			lowPowerMode <= 1'b0;
		else
			lowPowerMode <= sleepIn && !wakeReq;
	end
endmodule
`default_nettype wire

/* bench/irq_priority_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_priority_controller_bench;
	import ipc_pkg::*;
	localparam logic [15:0] BASE = 16'hf0e0;
	logic sysClk = 1'b0;
	logic rstN = 1'b0;
	logic busSel = 1'b0;
	logic busWr = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic [15:0] busWdata = 16'h0000;
	logic [15:0] busRdata;
	logic busRdValid;
	logic [NUM_SRC-1:0] irqReq = '0;
	logic [1:0] maskIn = 2'h0;
	logic [1:0] coreMask;
	logic sleepIn = 1'b0;
	logic lowPowerMode, irqAsserted, fastHit, wakeReq, expAsserted, expFast;
	logic [1:0] irqLevel, expLevel, expIpic;
	logic [5:0] vecNum, expVec;
	logic [21:0] vecAddr, expAddr;
	logic [63:0] expPend;
	logic [15:0] regVal [0:13];
	int nMismatch = 0;
	int checkCount = 0;
	int cycles = 0;
	always #2 sysClk = ~sysClk;
	ipc_irq_arbiter #(.BASE_ADDR(BASE)) uut (.sys_clk(sysClk), .rst_n(rstN), .busSel, .busWr, .busAddr,
		.busWdata, .busRdata, .busRdValid, .irqReq, .coreMask, .lowPowerMode, .irqAsserted, .irqLevel,
		.vecNum, .vecAddr, .fastHit, .wakeReq);
	ipc_core_model model (.sysClk, .rstN, .maskIn, .sleepIn, .wakeReq, .coreMask, .lowPowerMode);
	task automatic testDone();
		if (nMismatch == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] off, input logic [15:0] d);
		@(posedge sysClk);
		#1;
		busSel = 1'b1;
		busWr = 1'b1;
		busAddr = BASE + {11'h000, off};
		busWdata = d;
		@(posedge sysClk);
		#1;
		busSel = 1'b0;
	endtask
	task automatic rdChk(input logic [4:0] off, input logic [15:0] e);
		@(posedge sysClk);
		#1;
		busSel = 1'b1;
		busWr = 1'b0;
		busAddr = BASE + {11'h000, off};
		@(posedge sysClk);
		#1;
		busSel = 1'b0;
		chk({15'h0000, busRdValid, busRdata}, {16'h0001, e});
	endtask
	function automatic void predict();
		int best;
		logic [1:0] code;
		best = -1;
		expVec = 6'h00;
		expPend = '0;
		for (int s = 0; s < NUM_FIELD_SRC; s++)
		begin
			code = regVal[s / 8][2 * (7 - s % 8) +: 2];
			if (code != LEVEL_OFF && irqReq[s] && int'(code) - int'(s >= 8) > best)
			begin
				best = int'(code) - int'(s >= 8);
				expVec = 6'(s);
			end
			expPend[s] = code != LEVEL_OFF && irqReq[s];
		end
		expAsserted = best >= int'(maskIn);
		expLevel = 2'(best);
		expIpic = !expAsserted ? 2'h0 : expLevel == 2'h0 ? 2'h1 : expLevel == 2'h1 ? 2'h2 : 2'h3;
		expFast = best == 2 && (regVal[8][5:0] == expVec || regVal[11][5:0] == expVec);
		expAddr = !expFast ? {regVal[7], expVec} : regVal[8][5:0] == expVec ?
			{regVal[10][5:0], regVal[9]} : {regVal[13][5:0], regVal[12]};
	endfunction
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			nMismatch++;
			testDone();
		end
	end
	initial
	begin
		expPend = 64'($urandom(32'h460b4026));
		repeat (3) @(posedge sysClk);
		#1;
		rstN = 1'b1;
		for (int i = 0; i < 14; i++)
		begin
			regVal[i] = 16'h0000;
			rdChk(5'(i), 16'h0000);
		end
		wr(5'h12, 16'hffff);
		rdChk(5'h12, 16'h0000);
		wr(5'h00, 16'hffff);
		wr(5'h01, 16'hffff);
		rdChk(5'h00, 16'hf3ff);
		rdChk(5'h01, 16'hc03f);
		for (int n = 0; n < 300; n++)
		begin
			for (int k = 0; k < 14; k++)
			begin
				regVal[k] = 16'($urandom);
				regVal[k] &= k == 0 ? 16'hf3ff : k == 1 ? 16'hc03f :
					(k == 8 || k == 11) ? 16'h000f : 16'hffff;
				wr(5'(k), regVal[k]);
			end
			irqReq = {$urandom, $urandom};
			maskIn = 2'($urandom_range(3));
			predict();
			repeat (2) @(posedge sysClk);
			#1;
			chk({31'h0, irqAsserted}, {31'h0, expAsserted});
			if (expAsserted)
				chk({1'b0, irqLevel, vecNum, fastHit, vecAddr}, {1'b0, expLevel, expVec, expFast, expAddr});
			for (int p = 0; p < 4; p++)
				rdChk(5'(14 + p), expPend[16 * p +: 16]);
		end
		wr(5'h16, 16'h0020);
		repeat (2) @(posedge sysClk);
		#1;
		chk({31'h0, irqAsserted}, 32'h0000_0000);
		rdChk(5'h16, 16'h0020);
		rdChk(5'h0f, 16'h0000);
		wr(5'h16, 16'h0000);
		irqReq = '1;
		maskIn = 2'h0;
		predict();
		repeat (2) @(posedge sysClk);
		#1;
		chk({31'h0, irqAsserted}, {31'h0, expAsserted});
		chk({1'b0, irqLevel, vecNum, fastHit, vecAddr}, {1'b0, expLevel, expVec, expFast, expAddr});
		rdChk(5'h16, {expIpic, 1'b0, expAsserted, 12'h000});
		irqReq = '0;
		maskIn = 2'h0;
		wr(5'h00, 16'h0001);
		wr(5'h01, 16'h0000);
		sleepIn = 1'b1;
		repeat (2) @(posedge sysClk);
		wr(5'h01, 16'h0001);
		irqReq[15] = 1'b1;
		repeat (3) @(posedge sysClk);
		#1;
		chk({31'h0, wakeReq}, 32'h0000_0000);
		irqReq[7] = 1'b1;
		@(posedge sysClk);
		#1;
		chk({31'h0, wakeReq}, 32'h0000_0001);
		sleepIn = 1'b0;
		repeat (3) @(posedge sysClk);
		testDone();
	end
endmodule
`default_nettype wire
